/* include/adcbs_pkg.sv */
// Shared types and constants for the converter boundary-scan control cells
package adcbs_pkg;

  // Converter control cells, most significant first in the scan chain
  typedef struct packed {
    logic       gain_clock;
    logic       gain_path_enable;
    logic       bandgap_neg_select;
    logic       converter_power;
    logic       gain_stage_power;
    logic [9:0] compare_value;
    logic       gain_bypass_select;
    logic       gain_ten_enable;
    logic       gain_twenty_enable;
    logic       neg_input_ground_select;
    logic       sample_hold;
    logic       bandgap_ladder_ref_enable;
    logic [7:0] channel_select_bit;
    logic [2:0] neg_input_select_bit;
    logic       gain_pass_gate_enable;
    logic       comparator_precharge_n;
    logic       switchcap_test_route;
    logic       settle_assist;
    logic       supply_reference_select;
  } adcbs_ctrl_t;

  localparam int ADCBS_CTRL_W  = $bits(adcbs_ctrl_t);
  localparam int ADCBS_CHAIN_W = ADCBS_CTRL_W + 1;
  localparam int ADCBS_COMP_POS = ADCBS_CHAIN_W - 1;
  // Position of compare_value bit 0 inside the control word
  localparam int ADCBS_CMP_LSB = 22;
  localparam int ADCBS_HI_W    = ADCBS_CTRL_W - 32;

  // Quiet state applied at reset and in test-logic-reset
  localparam adcbs_ctrl_t ADCBS_SAFE_CTRL = '{
    gain_clock:                1'b0,
    gain_path_enable:          1'b0,
    bandgap_neg_select:        1'b0,
    converter_power:           1'b0,
    gain_stage_power:          1'b0,
    compare_value:             10'h200,
    gain_bypass_select:        1'b1,
    gain_ten_enable:           1'b0,
    gain_twenty_enable:        1'b0,
    neg_input_ground_select:   1'b0,
    sample_hold:               1'b1,
    bandgap_ladder_ref_enable: 1'b0,
    channel_select_bit:        8'h01,
    neg_input_select_bit:      3'h0,
    gain_pass_gate_enable:     1'b1,
    comparator_precharge_n:    1'b1,
    switchcap_test_route:      1'b0,
    settle_assist:             1'b0,
    supply_reference_select:   1'b0
  };

  typedef enum logic [3:0] {
    ADCBS_TLR, ADCBS_RTI, ADCBS_SEL_DR, ADCBS_CAP_DR, ADCBS_SHIFT_DR, ADCBS_EX1_DR,
    ADCBS_PAUSE_DR, ADCBS_EX2_DR, ADCBS_UPD_DR, ADCBS_SEL_IR, ADCBS_CAP_IR,
    ADCBS_SHIFT_IR, ADCBS_EX1_IR, ADCBS_PAUSE_IR, ADCBS_EX2_IR, ADCBS_UPD_IR
  } adcbs_tap_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } adcbs_link_t;

  localparam int ADCBS_SYNC_W = 4;

  // APB register map
  localparam int         ADCBS_ADDR_W      = 12;
  localparam logic [11:0] ADCBS_CTRL_OFF    = 12'h000;
  localparam logic [11:0] ADCBS_STATUS_OFF  = 12'h004;
  localparam logic [11:0] ADCBS_APPL_LO_OFF = 12'h008;
  localparam logic [11:0] ADCBS_APPL_HI_OFF = 12'h00C;
  localparam int ADCBS_CTRL_DRIVE_BIT   = 0;
  localparam int ADCBS_STAT_COMP_BIT    = 0;
  localparam int ADCBS_STAT_TLR_BIT     = 1;
  localparam int ADCBS_STAT_DRIVE_BIT   = 2;

  typedef struct packed {
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [ADCBS_ADDR_W-1:0] paddr;
    logic [31:0]             pwdata;
  } adcbs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } adcbs_apb_rsp_t;

endpackage

/* rtl/adcbs_sync.sv */
// Two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module adcbs_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,  // System clock
  input  wire logic         nrst,   // Synchronous reset, active low
  input  wire logic         ce,     // Clock enable
  input  wire logic [W-1:0] d,      // Asynchronous inputs
  output logic      [W-1:0] q       // Synchronised outputs
);
  logic [W-1:0] stage1;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      stage1 <= '0;
      q      <= '0;
    end
    else if (ce)
    begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule

/* rtl/adcbs_apb.sv */
// APB slave holding the scan drive control and converter status views
`timescale 1ns/1ps
module adcbs_apb (
  input  wire logic                    clock,      // System clock
  input  wire logic                    nrst,       // Synchronous reset, active low
  input  wire logic                    ce,         // Clock enable
  input  wire adcbs_pkg::adcbs_apb_req_t req,      // APB request
  output adcbs_pkg::adcbs_apb_rsp_t    rsp,        // APB response
  output logic                         scan_drive, // Scan cells drive the converter
  input  wire logic                    comp_seen,  // Synchronised comparator result
  input  wire logic                    tap_reset,  // Link controller in test-logic-reset
  input  wire adcbs_pkg::adcbs_ctrl_t  applied     // Controls now applied
);
  import adcbs_pkg::*;

  logic [31:0] rdata_q;
  logic        err_q;
  logic        loaded;
  logic        ready;
  logic [31:0] next_rdata;
  logic        next_err;

  function automatic logic hit(input logic [ADCBS_ADDR_W-1:0] a,
                               input logic [ADCBS_ADDR_W-1:0] off);
    return a == off;
  endfunction

  always_ff @(posedge clock)
  begin
    if (!nrst)
      scan_drive <= 1'b0;
    else if (ready && req.psel && req.penable && req.pwrite && hit(req.paddr, ADCBS_CTRL_OFF))
      scan_drive <= req.pwdata[ADCBS_CTRL_DRIVE_BIT];
  end

  always_comb
  begin
    next_rdata = '0;
    next_err   = 1'b0;
    if (hit(req.paddr, ADCBS_CTRL_OFF))
      next_rdata[ADCBS_CTRL_DRIVE_BIT] = scan_drive;
    else if (hit(req.paddr, ADCBS_STATUS_OFF))
    begin
      next_rdata[ADCBS_STAT_COMP_BIT]  = comp_seen;
      next_rdata[ADCBS_STAT_TLR_BIT]   = tap_reset;
      next_rdata[ADCBS_STAT_DRIVE_BIT] = scan_drive;
    end
    else if (hit(req.paddr, ADCBS_APPL_LO_OFF))
      next_rdata = applied[31:0];
    else if (hit(req.paddr, ADCBS_APPL_HI_OFF))
      next_rdata[ADCBS_HI_W-1:0] = applied[ADCBS_CTRL_W-1:32];
    else
      next_err = 1'b1;
  end

  // A setup edge lost to a frozen cycle is made up at the next enabled edge
  always_ff @(posedge clock)
  begin
    if (!nrst)
      loaded <= 1'b0;
    else if (ce && req.psel)
      loaded <= !(req.penable && loaded);
  end

  assign ready = ce & loaded;

  // Read data is latched once per transfer so it comes from a flop in the access cycle
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      rdata_q <= '0;
      err_q   <= 1'b0;
    end
    else if (ce && req.psel && !loaded)
    begin
      rdata_q <= next_rdata;
      err_q   <= next_err;
    end
  end

  // A frozen block stalls the bus rather than answering with stale data
  assign rsp = '{prdata: rdata_q, pready: ready, pslverr: err_q & req.psel & req.penable};
endmodule

/* rtl/adcbs_top.sv */
// Boundary-scan control and observe cells for the converter analog macro
//
// Behaviour
// R1 - Ten-bit comparison value, bit 9 most significant
// R2 - Low cells drive ladder code, bit 0 LSB
// R3 - Bypass select routes channels 0-3 past gains
// R4 - Ground select ties negative input low
// R5 - Sample-hold low tracks, high freezes
// R6 - Controller raises hold only while gain clock high
// R7 - Internal-reference control picks bandgap for ladder
// R8 - Three-bit negative select, bit 2 MSB
// R9 - Pass-gate control enables gain pass gate
// R10 - Precharge control active low on comparator latch
// R11 - Switch-cap test sends x10 output out
// R12 - Controller may pulse settle assist after power-up
// R13 - Supply-reference control selects supply as reference
// R14 - Controller selects exactly one negative source
// R15 - Controller drives quiet values when converter unused
// R16 - Controller should avoid gain stages during scan
// R17 - Gain clock cell clocks switched-capacitor stages
// R18 - Gain power control powers the gain stages
// R19 - Comparator result captured into observe cell
// R20 - All control cells apply together at update
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module adcbs_top (
  input  wire logic                     clock,     // System clock, 10 MHz
  input  wire logic                     nrst,      // Synchronous reset, active low
  input  wire logic                     ce,        // Clock enable, freezes all state when low
  input  wire adcbs_pkg::adcbs_link_t   link,      // Test access pins tck, tms, tdi
  output logic                          tdo,       // Test data out
  output logic                          tdo_oe,    // High while tdo is driven
  input  wire logic                     comp_in,   // Raw comparator result from the macro
  input  wire adcbs_pkg::adcbs_ctrl_t   func_ctrl, // Controls from the converter core logic
  output adcbs_pkg::adcbs_ctrl_t        conv_ctrl, // Controls applied to the analog macro
  input  wire adcbs_pkg::adcbs_apb_req_t apb_req,  // APB request
  output adcbs_pkg::adcbs_apb_rsp_t     apb_rsp    // APB response
);
  import adcbs_pkg::*;

  logic [ADCBS_SYNC_W-1:0]  sync_q;
  logic                     tck_s;
  logic                     tms_s;
  logic                     tdi_s;
  logic                     comp_s;
  logic                     tck_prev;
  logic                     tck_rise;
  logic                     tck_fall;
  adcbs_tap_t               tap_state;
  adcbs_tap_t               next_tap_state;
  logic [ADCBS_CHAIN_W-1:0] shift_reg;
  adcbs_ctrl_t              upd;
  logic                     scan_drive;

  adcbs_sync #(
    .W (ADCBS_SYNC_W)
  ) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .d     ({link.tck, link.tms, link.tdi, comp_in}),
    .q     (sync_q)
  );

  assign {tck_s, tms_s, tdi_s, comp_s} = sync_q;

  // Link clock is only sampled; 8 system clocks per link period leave margin
  always_ff @(posedge clock)
  begin
    if (!nrst)
      tck_prev <= 1'b0;
    else if (ce)
      tck_prev <= tck_s;
  end

  assign tck_rise = tck_s & ~tck_prev;
  assign tck_fall = ~tck_s & tck_prev;

  always_comb
  begin
    unique case (tap_state)
      ADCBS_TLR:      next_tap_state = tms_s ? ADCBS_TLR      : ADCBS_RTI;
      ADCBS_RTI:      next_tap_state = tms_s ? ADCBS_SEL_DR   : ADCBS_RTI;
      ADCBS_SEL_DR:   next_tap_state = tms_s ? ADCBS_SEL_IR   : ADCBS_CAP_DR;
      ADCBS_CAP_DR:   next_tap_state = tms_s ? ADCBS_EX1_DR   : ADCBS_SHIFT_DR;
      ADCBS_SHIFT_DR: next_tap_state = tms_s ? ADCBS_EX1_DR   : ADCBS_SHIFT_DR;
      ADCBS_EX1_DR:   next_tap_state = tms_s ? ADCBS_UPD_DR   : ADCBS_PAUSE_DR;
      ADCBS_PAUSE_DR: next_tap_state = tms_s ? ADCBS_EX2_DR   : ADCBS_PAUSE_DR;
      ADCBS_EX2_DR:   next_tap_state = tms_s ? ADCBS_UPD_DR   : ADCBS_SHIFT_DR;
      ADCBS_UPD_DR:   next_tap_state = tms_s ? ADCBS_SEL_DR   : ADCBS_RTI;
      ADCBS_SEL_IR:   next_tap_state = tms_s ? ADCBS_TLR      : ADCBS_CAP_IR;
      ADCBS_CAP_IR:   next_tap_state = tms_s ? ADCBS_EX1_IR   : ADCBS_SHIFT_IR;
      ADCBS_SHIFT_IR: next_tap_state = tms_s ? ADCBS_EX1_IR   : ADCBS_SHIFT_IR;
      ADCBS_EX1_IR:   next_tap_state = tms_s ? ADCBS_UPD_IR   : ADCBS_PAUSE_IR;
      ADCBS_PAUSE_IR: next_tap_state = tms_s ? ADCBS_EX2_IR   : ADCBS_PAUSE_IR;
      ADCBS_EX2_IR:   next_tap_state = tms_s ? ADCBS_UPD_IR   : ADCBS_SHIFT_IR;
      ADCBS_UPD_IR:   next_tap_state = tms_s ? ADCBS_SEL_DR   : ADCBS_RTI;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      tap_state <= ADCBS_TLR;
    else if (ce && tck_rise)
      tap_state <= next_tap_state;
  end

  // Capture reads back what the macro really sees, topped by the comparator result
  always_ff @(posedge clock)
  begin
    if (!nrst)
      shift_reg <= '0;
    else if (ce && tck_rise && tap_state == ADCBS_CAP_DR)
      shift_reg <= {comp_s, conv_ctrl};  // see R19
    else if (ce && tck_rise && tap_state == ADCBS_SHIFT_DR)
      shift_reg <= {tdi_s, shift_reg[ADCBS_CHAIN_W-1:1]};
  end

  // Update on the falling link edge so shifting never disturbs the applied controls
  always_ff @(posedge clock)
  begin
    if (!nrst)
      upd <= ADCBS_SAFE_CTRL;
    else if (ce && tap_state == ADCBS_TLR)
      upd <= ADCBS_SAFE_CTRL;
    else if (ce && tck_fall && tap_state == ADCBS_UPD_DR)
      upd <= shift_reg[ADCBS_CTRL_W-1:0];  // see R20
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (ce && tck_fall)
    begin
      tdo    <= shift_reg[0];
      tdo_oe <= (tap_state == ADCBS_SHIFT_DR);
    end
  end

  // Each field goes to the macro unchanged; the macro's switches do the routing
  always_ff @(posedge clock)
  begin
    if (!nrst)
      conv_ctrl <= ADCBS_SAFE_CTRL;
    else if (ce)
      conv_ctrl <= scan_drive ? upd : func_ctrl;  // see R1 see R3 see R17 see R18
  end

  adcbs_apb u_apb (
    .clock      (clock),
    .nrst       (nrst),
    .ce         (ce),
    .req        (apb_req),
    .rsp        (apb_rsp),
    .scan_drive (scan_drive),
    .comp_seen  (comp_s),
    .tap_reset  (tap_state == ADCBS_TLR),
    .applied    (conv_ctrl)
  );

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_update;
    ce && tck_fall && tap_state == ADCBS_UPD_DR;
  endsequence

  sequence s_driving;
    ce && scan_drive;
  endsequence

  // Link edges as the state machine sees them, frozen with the clock enable
  sequence s_rise;
    ce && tck_rise;
  endsequence

  sequence s_fall;
    ce && tck_fall;
  endsequence

  a_update_load: assert property (s_update |=> upd == $past(shift_reg[ADCBS_CTRL_W-1:0])) // see R20
    else $error("update did not load the shifted control word");

  a_update_hold: assert property (
    !(ce && tck_fall && tap_state == ADCBS_UPD_DR) && !(ce && tap_state == ADCBS_TLR)
    |=> $stable(upd)) // see R20
    else $error("applied controls changed outside the update step");

  a_cmp_value: assert property (s_driving |=> conv_ctrl.compare_value == $past(upd.compare_value)) // see R1
    else $error("comparison value not applied");

  a_cmp_lsb_path: assert property (s_update ##1 s_driving
    |=> conv_ctrl.compare_value[0] == $past(shift_reg[ADCBS_CMP_LSB], 2)) // see R2
    else $error("comparison value bit 0 not taken from its cell");

  a_bypass_route: assert property (s_driving and upd.gain_bypass_select
    |=> conv_ctrl.gain_bypass_select) // see R3
    else $error("bypass select not applied");

  a_ground_neg: assert property (s_driving
    |=> conv_ctrl.neg_input_ground_select == $past(upd.neg_input_ground_select)) // see R4
    else $error("ground select not applied");

  a_sample_hold: assert property (s_driving [*2]
    |-> conv_ctrl.sample_hold == $past(upd.sample_hold)) // see R5
    else $error("sample-hold not applied");

  a_bandgap_ref: assert property (ce && !scan_drive
    |=> conv_ctrl.bandgap_ladder_ref_enable == $past(func_ctrl.bandgap_ladder_ref_enable)) // see R7
    else $error("core reference control not passed when scan idle");

  a_bandgap_scan: assert property (s_driving
    |=> conv_ctrl.bandgap_ladder_ref_enable == $past(upd.bandgap_ladder_ref_enable)) // see R7
    else $error("internal reference control not applied");

  a_neg_select: assert property (s_driving
    |=> conv_ctrl.neg_input_select_bit == $past(upd.neg_input_select_bit)) // see R8
    else $error("negative input select not applied");

  a_pass_gate: assert property (s_driving
    |=> conv_ctrl.gain_pass_gate_enable == $past(upd.gain_pass_gate_enable)) // see R9
    else $error("pass-gate control not applied");

  a_precharge_low: assert property (s_driving and !upd.comparator_precharge_n
    |=> !conv_ctrl.comparator_precharge_n) // see R10
    else $error("precharge not asserted low");

  a_switchcap_route: assert property (s_driving
    |=> conv_ctrl.switchcap_test_route == $past(upd.switchcap_test_route)) // see R11
    else $error("switch-cap test route not applied");

  a_supply_ref: assert property (s_driving
    |=> conv_ctrl.supply_reference_select == $past(upd.supply_reference_select)) // see R13
    else $error("supply reference select not applied");

  a_gain_clock: assert property (s_driving
    |=> conv_ctrl.gain_clock == $past(upd.gain_clock)) // see R17
    else $error("gain clock cell not applied");

  a_gain_power: assert property (s_driving
    |=> conv_ctrl.gain_stage_power == $past(upd.gain_stage_power)) // see R18
    else $error("gain power not applied");

  a_comp_capture: assert property (ce && tck_rise && tap_state == ADCBS_CAP_DR
    |=> shift_reg[ADCBS_COMP_POS] == $past(comp_s)) // see R19
    else $error("comparator result not captured");

  a_tdo_launch: assert property (s_fall |=> tdo == $past(shift_reg[0])) // see R19
    else $error("test data out not launched on a falling link edge");

  a_tdo_enable: assert property (s_fall |=> tdo_oe == ($past(tap_state) == ADCBS_SHIFT_DR))
    else $error("output enable does not follow the shift state");

  a_tdo_hold: assert property (!(ce && tck_fall) |=> $stable(tdo) && $stable(tdo_oe))
    else $error("test data out moved between falling link edges");

  a_tap_advance: assert property (s_rise |=> tap_state == $past(next_tap_state))
    else $error("link state did not advance on a rising link edge");

  a_tap_hold: assert property (!(ce && tck_rise) |=> $stable(tap_state))
    else $error("link state moved without a rising link edge");

  a_shift_move: assert property (s_rise and tap_state == ADCBS_SHIFT_DR
    |=> shift_reg == {$past(tdi_s), $past(shift_reg[ADCBS_CHAIN_W-1:1])})
    else $error("scan chain did not move one place toward the output");

  a_capture_ctrl: assert property (s_rise and tap_state == ADCBS_CAP_DR // see R19
    |=> shift_reg[ADCBS_CTRL_W-1:0] == $past(conv_ctrl))
    else $error("capture did not read back the applied controls");

  a_tlr_reload: assert property (ce && tap_state == ADCBS_TLR
    |=> upd == ADCBS_SAFE_CTRL)
    else $error("test-logic-reset did not restore the quiet controls");

  a_freeze_all: assert property (!ce
    |=> $stable(conv_ctrl) && $stable(shift_reg) && $stable(tap_state) && $stable(upd))
    else $error("state moved while the clock enable was low");

  a_bypass_clear: assert property (s_driving and !upd.gain_bypass_select // see R3
    |=> !conv_ctrl.gain_bypass_select)
    else $error("bypass select not released");

  a_precharge_free: assert property (s_driving and upd.comparator_precharge_n // see R10
    |=> conv_ctrl.comparator_precharge_n)
    else $error("precharge not released high");

  a_gain_enables: assert property (s_driving
    |=> conv_ctrl.gain_ten_enable == $past(upd.gain_ten_enable)
        && conv_ctrl.gain_twenty_enable == $past(upd.gain_twenty_enable))
    else $error("gain enables not applied");

  a_channel_mux: assert property (s_driving
    |=> conv_ctrl.channel_select_bit == $past(upd.channel_select_bit))
    else $error("channel select not applied");

  a_core_path: assert property (ce && !scan_drive |=> conv_ctrl == $past(func_ctrl))
    else $error("core controls not passed while scan is idle");

  a_scan_path: assert property (s_driving |=> conv_ctrl == $past(upd)) // see R20
    else $error("scan controls not applied as one word");

endmodule

/* tb/adcbs_tap_model.sv */
// Behavioural test-access-port controller driving the scan link
`timescale 1ns/1ps
module adcbs_tap_model (
  input  wire logic             clock,  // System clock
  input  wire logic             tdo,    // Test data out from the block
  input  wire logic             tdo_oe, // Block drives tdo
  output adcbs_pkg::adcbs_link_t link,  // Link pins tck, tms, tdi
  output logic [38:0]           cap,    // Output enable and bits shifted out
  output logic                  done,   // Scan finished, cap valid
  output logic                  mid     // Halfway through a shift
);
  import adcbs_pkg::*;

  initial
  begin
    link = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};
    cap  = '0;
    done = 1'b0;
    mid  = 1'b0;
  end

  always @(posedge clock)
  begin
    if (done) done <= 1'b0;
    if (mid) mid <= 1'b0;
  end

  // High 3 clocks, low 5: 800 ns, and tdo has settled before the next rise
  task automatic step(input logic m, input logic d, output logic o, output logic e);
    @(posedge clock);
    link.tms <= m;
    link.tdi <= d;
    link.tck <= 1'b1;
    repeat (3) @(posedge clock);
    link.tck <= 1'b0;
    repeat (4) @(posedge clock);
    o = tdo;
    e = tdo_oe;
  endtask

  task automatic scan(input adcbs_ctrl_t v);
    logic [37:0] din;
    logic [37:0] b;
    logic        o;
    logic        e;
    logic        oe;
    din = {1'b0, v};
    step(1'b0, 1'b0, o, e);
    step(1'b1, 1'b0, o, e);
    step(1'b0, 1'b0, o, e);
    step(1'b0, 1'b0, o, e);
    oe = e;
    for (int i = 0; i < 38; i++)
    begin
      b[i] = o;
      oe   = oe & e;
      step(i == 37, din[i], o, e);
      if (i == 19) mid <= 1'b1;
    end
    step(1'b1, 1'b0, o, e);
    step(1'b0, 1'b0, o, e);
    cap  <= {oe, b};
    done <= 1'b1;
    // Released tdi must not look like a held value
    link.tdi <= ~link.tdi;
  endtask

  task automatic reset_tap();
    logic o;
    logic e;
    repeat (5) step(1'b1, 1'b0, o, e);
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the converter boundary-scan control cells
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module testbench;
  import adcbs_pkg::*;

  logic           clock;
  logic           nrst;
  logic           ce;
  adcbs_link_t    link;
  logic           tdo;
  logic           tdo_oe;
  logic           comp_in;
  adcbs_ctrl_t    func_ctrl;
  adcbs_ctrl_t    conv_ctrl;
  adcbs_apb_req_t apb_req;
  adcbs_apb_rsp_t apb_rsp;
  logic [38:0]    tap_cap;
  logic           tap_done;
  logic           tap_mid;
  logic           snap;
  logic [63:0]    exp_q[$];
  int             err_count;
  int             checked;
  adcbs_ctrl_t    prev;
  adcbs_ctrl_t    v;

  adcbs_top adcbs_top_i (.clock(clock), .nrst(nrst), .ce(ce), .link(link), .tdo(tdo),
    .tdo_oe(tdo_oe), .comp_in(comp_in), .func_ctrl(func_ctrl), .conv_ctrl(conv_ctrl),
    .apb_req(apb_req), .apb_rsp(apb_rsp));

  adcbs_tap_model adcbs_tap_model_i (.clock(clock), .tdo(tdo), .tdo_oe(tdo_oe), .link(link),
    .cap(tap_cap), .done(tap_done), .mid(tap_mid));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic report_and_stop();
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_next(input logic [63:0] act);
    logic [63:0] e;
    e = exp_q.size() ? exp_q.pop_front() : ~act;
    `CHK(act, e)
  endtask

  // Results are compared in the order the driver noted them
  always @(posedge clock)
    if (nrst)
    begin
      if (apb_req.psel && apb_req.penable && apb_rsp.pready && !apb_req.pwrite)
        chk_next({31'h0, apb_rsp.pslverr, apb_rsp.prdata});
      if (tap_mid || snap)
        chk_next({27'h0, conv_ctrl});
      if (tap_done)
        chk_next({25'h0, tap_cap});
    end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do @(posedge clock); while (apb_rsp.pready !== 1'b1);
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
    exp_q.push_back({31'h0, err, d});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic take_snap(input adcbs_ctrl_t e);
    repeat (3) @(posedge clock);
    exp_q.push_back({27'h0, e});
    snap <= 1'b1;
    @(posedge clock);
    snap <= 1'b0;
  endtask

  // Gain stages stay off and ground is the only negative source
  function automatic adcbs_ctrl_t mk(input logic [9:0] cmp);
    adcbs_ctrl_t c;
    c = ADCBS_SAFE_CTRL;
    c.compare_value             = cmp;
    c.converter_power           = 1'b1;
    c.neg_input_ground_select   = 1'b1;
    c.channel_select_bit        = 8'h01 << $urandom_range(7);
    c.sample_hold               = 1'(($urandom));
    c.comparator_precharge_n    = 1'(($urandom));
    c.switchcap_test_route      = 1'(($urandom));
    c.gain_bypass_select        = 1'(($urandom));
    c.gain_pass_gate_enable     = 1'(($urandom));
    c.bandgap_ladder_ref_enable = 1'(($urandom));
    c.supply_reference_select   = ~c.bandgap_ladder_ref_enable;
    return c;
  endfunction

  initial
  begin
    #1_000_000;
    err_count++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(90051));
    nrst      = 1'b0;
    ce        = 1'b1;
    comp_in   = 1'b0;
    snap      = 1'b0;
    func_ctrl = ADCBS_SAFE_CTRL;
    apb_req   = '0;
    err_count = 0;
    checked   = 0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    rd(ADCBS_STATUS_OFF, 32'h2, 1'b0);
    rd(ADCBS_APPL_LO_OFF, ADCBS_SAFE_CTRL[31:0], 1'b0);
    rd(ADCBS_APPL_HI_OFF, {27'h0, ADCBS_SAFE_CTRL[36:32]}, 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    func_ctrl <= adcbs_ctrl_t'(37'({$urandom(), $urandom()}));
    @(posedge clock);
    take_snap(func_ctrl);
    apb(1'b1, ADCBS_CTRL_OFF, 32'h1);
    apb(1'b1, ADCBS_STATUS_OFF, 32'h0);
    rd(ADCBS_STATUS_OFF, 32'h6, 1'b0);
    prev = ADCBS_SAFE_CTRL;
    for (int n = 0; n < 4; n++)
    begin
      comp_in <= n[0];
      v = mk(n == 0 ? 10'h000 : n == 1 ? 10'h3FF : 10'($urandom));
      repeat (4) @(posedge clock);
      exp_q.push_back({27'h0, prev});
      exp_q.push_back({25'h0, 1'b1, n[0], prev});
      adcbs_tap_model_i.scan(v);
      take_snap(v);
      rd(ADCBS_APPL_LO_OFF, v[31:0], 1'b0);
      rd(ADCBS_APPL_HI_OFF, {27'h0, v[36:32]}, 1'b0);
      prev = v;
    end
    adcbs_tap_model_i.reset_tap();
    take_snap(ADCBS_SAFE_CTRL);
    // A read whose setup edge falls in a frozen cycle must still return fresh data
    ce <= 1'b0;
    fork
      rd(ADCBS_STATUS_OFF, 32'h7, 1'b0);
      begin
        repeat (3) @(posedge clock);
        ce <= 1'b1;
      end
    join
    apb(1'b1, ADCBS_CTRL_OFF, 32'h0);
    func_ctrl <= adcbs_ctrl_t'(37'({$urandom(), $urandom()}));
    @(posedge clock);
    take_snap(func_ctrl);
    repeat (4) @(posedge clock);
    report_and_stop();
  end
endmodule
